/* hdl/pulse_accumulator.sv */
// pulse accumulator: event counter / gated time accumulator with avalon-mm registers
`timescale 1ns/100ps
`include "pulse_accumulator_map.svh"

module pulse_accumulator
  import pulse_accumulator_pkg::*;
#(
  parameter int COUNT_WIDTH = 8,
  parameter int GATE_DIVIDE = `PA_GATE_DIVIDE
)
(
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst_b,
  input  wire logic [3:0]                    i_avs_address,
  input  wire logic                          i_avs_read,
  input  wire logic                          i_avs_write,
  input  wire logic [31:0]                   i_avs_writedata,
  output logic      [31:0]                   o_avs_readdata,
  output logic                               o_avs_waitrequest,
  input  wire logic                          i_accum_input_pin,
  output logic                               o_output_compare_five_en,
  output logic                               o_input_capture_four_en,
  output logic                               o_port_a_bit7_direction,
  output logic                               o_port_a_bit3_direction,
  output logic [1:0]                         o_periodic_rate_select,
  output logic                               o_overflow_irq,
  output logic                               o_edge_irq
);
  import pulse_accumulator_pkg::*;

  // elaboration checks: the register map holds exactly eight count bits
  if (COUNT_WIDTH != 8) begin : g_bad_width
    $error("COUNT_WIDTH must be 8");
  end
  if (GATE_DIVIDE < 2 || GATE_DIVIDE > 256) begin : g_bad_div
    $error("GATE_DIVIDE out of range");
  end

  localparam logic [7:0] DIV_LAST = 8'(GATE_DIVIDE - 1);

  logic [7:0]             accum_control_reg_ff;
  logic [7:0]             timer_mask_reg_two_ff;
  logic [COUNT_WIDTH-1:0] accum_count_value_ff;
  logic                   count_overflow_flag_ff;
  logic                   input_edge_flag_ff;
  logic [2:0]             pin_sync_ff;
  logic                   pin_level_ff;
  logic [3:0]             primed_ff;
  logic [7:0]             div_ff;
  bus_state_t             bus_state_ff;
  bus_state_t             nxt_bus_state;
  logic [31:0]            rdata_ff;
  logic                   accum_enable_bit;
  accum_mode_t            accum_mode_select;
  logic                   edge_polarity_select;
  logic                   pin_rise;
  logic                   pin_fall;
  logic                   sel_edge;
  logic                   gate_tick;
  logic                   inc;
  logic                   wr_take;
  logic                   rd_take;
  logic [7:0]             wbyte;
  logic                   ovf_set;
  logic [7:0]             nxt_count;

  ////////////////////////////////////////////////////////////////////////////
  // control field decode
  assign accum_enable_bit     = accum_control_reg_ff[`PA_CTL_ENABLE];
  assign accum_mode_select    = accum_control_reg_ff[`PA_CTL_MODE] ? ACC_GATED : ACC_EVENT;
  assign edge_polarity_select = accum_control_reg_ff[`PA_CTL_EDGE];
  assign o_input_capture_four_en  = accum_control_reg_ff[`PA_CTL_CAP4_CMP5];
  assign o_output_compare_five_en = ~accum_control_reg_ff[`PA_CTL_CAP4_CMP5];
  assign o_port_a_bit7_direction  = accum_control_reg_ff[`PA_CTL_PORT_A_BIT7];
  assign o_port_a_bit3_direction  = accum_control_reg_ff[`PA_CTL_PORT_A_BIT3];
  assign o_periodic_rate_select   =
    accum_control_reg_ff[`PA_CTL_RATE_HI:`PA_CTL_RATE_LO];

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: stage 0 feeds only stage 1; a change counts once 1 and 2 agree
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      pin_sync_ff <= 3'h0;
    else
      pin_sync_ff <= {pin_sync_ff[1], pin_sync_ff[0], i_accum_input_pin};
  end

  // filtered level moves only when the last two stages agree
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      pin_level_ff <= 1'b0;
    else if (pin_sync_ff[1] == pin_sync_ff[2])
      pin_level_ff <= pin_sync_ff[2];
  end

  // edges count only once the filtered level holds real pin data: the level
  // resets low, so a pin idling high would otherwise fake a rise after reset
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      primed_ff <= 4'h0;
    else
      primed_ff <= {primed_ff[2:0], 1'b1};
  end

  // edges of the filtered level; an edge seen is one pulse
  assign pin_rise = primed_ff[3] & (pin_sync_ff[1] == pin_sync_ff[2]) &
                    pin_sync_ff[2] & ~pin_level_ff;
  assign pin_fall = primed_ff[3] & (pin_sync_ff[1] == pin_sync_ff[2]) &
                    ~pin_sync_ff[2] & pin_level_ff;
  assign sel_edge = edge_polarity_select ? pin_rise : pin_fall;

  ////////////////////////////////////////////////////////////////////////////
  // free-running divide-by-GATE_DIVIDE time base (64 by default), never stopped by the enable bit
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      div_ff <= 8'h00;
    else if (div_ff == DIV_LAST)
      div_ff <= 8'h00;
    else
      div_ff <= div_ff + 8'h01;
  end
  assign gate_tick = (div_ff == DIV_LAST);

  // increment source per mode; the gate is active where the inhibit level is absent
  always_comb
  begin
    inc = 1'b0;
    if (accum_enable_bit)
    begin
      unique case (accum_mode_select)
        ACC_EVENT: inc = sel_edge;
        ACC_GATED: inc = gate_tick & (pin_level_ff != edge_polarity_select);
        default:   inc = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: two wait cycles, then the answer; reads are sampled in the
  // setup phase and writes land on the done phase, so the two never collide
  always_comb
  begin
    nxt_bus_state = BUS_IDLE;
    unique case (bus_state_ff)
      BUS_IDLE:  nxt_bus_state = (i_avs_read | i_avs_write) ? BUS_SETUP : BUS_IDLE;
      BUS_SETUP: nxt_bus_state = BUS_DONE;
      BUS_DONE:  nxt_bus_state = BUS_IDLE;
      default:   nxt_bus_state = BUS_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      bus_state_ff <= BUS_IDLE;
    else
      bus_state_ff <= nxt_bus_state;
  end

  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & (bus_state_ff != BUS_DONE);
  assign wr_take = i_avs_write & (bus_state_ff == BUS_DONE);
  assign rd_take = i_avs_read & (bus_state_ff == BUS_SETUP);
  assign wbyte   = i_avs_writedata[7:0];

  // read data captured one cycle before the answer edge; unmapped reads zero
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      rdata_ff <= 32'h0000_0000;
    else if (rd_take)
    begin
      unique case (i_avs_address)
        `PA_ADDR_CONTROL: rdata_ff <= {24'h0, accum_control_reg_ff};
        `PA_ADDR_COUNT:   rdata_ff <= {24'h0, accum_count_value_ff};
        `PA_ADDR_MASK2:   rdata_ff <= {24'h0, timer_mask_reg_two_ff};
        `PA_ADDR_FLAG2:   rdata_ff <= {26'h0, count_overflow_flag_ff, input_edge_flag_ff, 4'h0};
        default:          rdata_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign o_avs_readdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // control and mask registers
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      accum_control_reg_ff <= `PA_CONTROL_RESET;
    else if (wr_take && i_avs_address == `PA_ADDR_CONTROL)
      accum_control_reg_ff <= wbyte;
  end

  // mask two: bits 3:2 unimplemented, read zero
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      timer_mask_reg_two_ff <= `PA_MASK2_RESET;
    else if (wr_take && i_avs_address == `PA_ADDR_MASK2)
      timer_mask_reg_two_ff <= wbyte & `PA_MASK2_WRITABLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter: no reset, so it keeps its value through reset; a software write
  // wins over an increment in the same cycle
  assign nxt_count = accum_count_value_ff + 8'h01;
  assign ovf_set   = inc & (accum_count_value_ff == 8'hFF) &
                     ~(wr_take && i_avs_address == `PA_ADDR_COUNT);

  always_ff @(posedge i_core_clk)
  begin
    if (wr_take && i_avs_address == `PA_ADDR_COUNT)
      accum_count_value_ff <= wbyte;
    else if (inc)
      accum_count_value_ff <= nxt_count;
  end

  // overflow flag: set beats clear in the same cycle
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      count_overflow_flag_ff <= 1'b0;
    else if (ovf_set)
      count_overflow_flag_ff <= 1'b1;
    else if (wr_take && i_avs_address == `PA_ADDR_FLAG2 && wbyte[`PA_BIT_OVERFLOW])
      count_overflow_flag_ff <= 1'b0;
  end

  // input-edge flag: only while enabled, in either mode; set beats clear
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      input_edge_flag_ff <= 1'b0;
    else if (accum_enable_bit && sel_edge)
      input_edge_flag_ff <= 1'b1;
    else if (wr_take && i_avs_address == `PA_ADDR_FLAG2 && wbyte[`PA_BIT_EDGE])
      input_edge_flag_ff <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt requests: mask bit gates flag in same position (levels)
  assign o_overflow_irq = count_overflow_flag_ff &
                          timer_mask_reg_two_ff[`PA_BIT_OVERFLOW];
  assign o_edge_irq     = input_edge_flag_ff &
                          timer_mask_reg_two_ff[`PA_BIT_EDGE];

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  AST_OVF_ON_ROLL: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    ovf_set |=> count_overflow_flag_ff && accum_count_value_ff == 8'h00)
    else $error("overflow flag not set on rollover");
  AST_OVF_CLEAR: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (wr_take && i_avs_address == `PA_ADDR_FLAG2 && wbyte[5] && !ovf_set)
      |=> !count_overflow_flag_ff)
    else $error("overflow flag not cleared");
  AST_OVF_KEEP: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (count_overflow_flag_ff && !(wr_take && i_avs_address == `PA_ADDR_FLAG2 && wbyte[5]))
      |=> count_overflow_flag_ff)
    else $error("overflow flag lost");
  AST_EDGE_CLEAR: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (wr_take && i_avs_address == `PA_ADDR_FLAG2 && wbyte[4] && !(accum_enable_bit && sel_edge))
      |=> !input_edge_flag_ff)
    else $error("edge flag not cleared");
  AST_OVF_IRQ: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_overflow_irq == (count_overflow_flag_ff && timer_mask_reg_two_ff[5]))
    else $error("overflow request wrong");
  AST_EDGE_IRQ: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (input_edge_flag_ff && timer_mask_reg_two_ff[4]) |-> o_edge_irq)
    else $error("edge request missing");
  AST_DISABLED_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (!accum_enable_bit && !(wr_take && i_avs_address == `PA_ADDR_COUNT))
      |=> $stable(accum_count_value_ff))
    else $error("count moved while disabled");
  AST_GATED_TICK: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (inc && accum_mode_select == ACC_GATED) |-> div_ff == DIV_LAST)
    else $error("gated increment off tick");
  AST_GATE_INHIBIT: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (accum_mode_select == ACC_GATED && pin_level_ff == edge_polarity_select) |-> !inc)
    else $error("count during inhibit level");
  AST_SELECT_EXCL: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_input_capture_four_en != o_output_compare_five_en)
    else $error("capture and compare both on");
  AST_WAIT_BOUND: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    ((i_avs_read || i_avs_write) && bus_state_ff == BUS_IDLE) |-> ##2 !o_avs_waitrequest)
    else $error("bus answer late");
  AST_OVF_EN_KEEP: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (wr_take && i_avs_address == `PA_ADDR_MASK2 && !ovf_set)
      |=> count_overflow_flag_ff == $past(count_overflow_flag_ff))
    else $error("overflow enable write altered flag");
  AST_EDGE_EN_KEEP: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (wr_take && i_avs_address == `PA_ADDR_MASK2 && !(accum_enable_bit && sel_edge))
      |=> input_edge_flag_ff == $past(input_edge_flag_ff))
    else $error("edge enable write altered flag");
  COV_ROLL:   cover property (@(posedge i_core_clk) disable iff (!i_rst_b) ovf_set);
  COV_EVENT:  cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
    inc && accum_mode_select == ACC_EVENT);
  COV_GATED:  cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
    inc && accum_mode_select == ACC_GATED);
  COV_IRQ:    cover property (@(posedge i_core_clk) disable iff (!i_rst_b) o_edge_irq);

endmodule : pulse_accumulator

/* hdl/pulse_accumulator_map.svh */
// register offsets, field positions, reset values and timing counts of the pulse accumulator
`ifndef PULSE_ACCUMULATOR_MAP_SVH
`define PULSE_ACCUMULATOR_MAP_SVH

// word indices on the register bus (byte address = index * 4)
`define PA_ADDR_CONTROL      4'h0
`define PA_ADDR_COUNT        4'h1
`define PA_ADDR_MASK2        4'h2
`define PA_ADDR_FLAG2        4'h3
// control register fields
`define PA_CTL_PORT_A_BIT7   7
`define PA_CTL_ENABLE        6
`define PA_CTL_MODE          5
`define PA_CTL_EDGE          4
`define PA_CTL_PORT_A_BIT3   3
`define PA_CTL_CAP4_CMP5     2
`define PA_CTL_RATE_HI       1
`define PA_CTL_RATE_LO       0
// mask two and flag two fields (same positions)
`define PA_BIT_OVERFLOW      5
`define PA_BIT_EDGE          4
`define PA_MASK2_WRITABLE    8'hF3
`define PA_FLAG2_FLAGS       8'hF0
// reset values
`define PA_CONTROL_RESET     8'h00
`define PA_MASK2_RESET       8'h00
`define PA_COUNT_POWERUP     8'h00
// gated time base: bus clock divided by 64
`define PA_GATE_DIVIDE       64

`endif

/* hdl/pulse_accumulator_pkg.sv */
// types shared by the pulse accumulator
package pulse_accumulator_pkg;
  typedef enum logic [1:0]
  {
    ACC_EVENT = 2'b00,
    ACC_GATED = 2'b01
  } accum_mode_t;
  typedef enum logic [1:0]
  {
    BUS_IDLE  = 2'b00,
    BUS_SETUP = 2'b01,
    BUS_DONE  = 2'b11
  } bus_state_t;
endpackage : pulse_accumulator_pkg

/* verification/pin_source.sv */
// pin source: drives the accumulator input with idle levels or pulse bursts
`timescale 1ns/100ps
module pin_source
(
  input  wire logic       i_core_clk,
  input  wire logic       i_idle,
  input  wire logic       i_start,
  input  wire logic [3:0] i_count,
  input  wire logic [3:0] i_half,
  output logic            o_pin,
  output logic            o_busy
);
  //////////////////////////////////////////////////////////////////////////////
  // power-up level before the first clock edge
  initial
  begin
    o_pin  = 1'b1;
    o_busy = 1'b0;
  end

  // each pulse leaves the idle level and returns to it
  // half period never below two cycles so the pin stays within clock/4
  always
  begin
    @(posedge i_core_clk);
    if (i_start)
    begin
      o_busy <= 1'b1;
      repeat (2 * i_count)
      begin
        repeat ((i_half < 4'h2) ? 4'h2 : i_half) @(posedge i_core_clk);
        o_pin <= ~o_pin;
      end
      o_busy <= 1'b0;
    end
    else
      o_pin <= i_idle;
  end
endmodule : pin_source

/* verification/pulse_accumulator_tb.sv */
// self-checking bench for the pulse accumulator
`timescale 1ns/100ps
`include "pulse_accumulator_map.svh"
module pulse_accumulator_tb;
  import pulse_accumulator_pkg::*;
  // short gate divider keeps the gated runs brief
  localparam int         DIV = 8;
  localparam logic [3:0] CTL = `PA_ADDR_CONTROL;
  localparam logic [3:0] CNT = `PA_ADDR_COUNT;
  localparam logic [3:0] MSK = `PA_ADDR_MASK2;
  localparam logic [3:0] FLG = `PA_ADDR_FLAG2;
  logic        clk, rst_b, rd, wr, wait_req, pin, idle, start, busy;
  logic        cmp5, cap4, dir7, dir3, ovf_irq, edge_irq;
  logic [31:0] wdata, rdata, q;
  logic [7:0]  d;
  logic [3:0]  addr, cnt, half;
  logic [1:0]  rate;
  int          fail_count, comparisons;
  //////////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  initial clk = 1'b0;
  always #50 clk = ~clk;

  pulse_accumulator #(.GATE_DIVIDE(DIV)) pulse_accumulator_inst
  (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .i_accum_input_pin(pin),
    .o_output_compare_five_en(cmp5), .o_input_capture_four_en(cap4),
    .o_port_a_bit7_direction(dir7), .o_port_a_bit3_direction(dir3),
    .o_periodic_rate_select(rate), .o_overflow_irq(ovf_irq), .o_edge_irq(edge_irq)
  );
  pin_source pin_source_inst
  (
    .i_core_clk(clk), .i_idle(idle), .i_start(start), .i_count(cnt),
    .i_half(half), .o_pin(pin), .o_busy(busy)
  );
  //////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task stop_test;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one bus cycle; request held until waitrequest is seen low at an edge
  task acc(input logic r, input logic [3:0] a, input logic [7:0] v);
    int k;
    @(posedge clk);
    rd    <= r;
    wr    <= ~r;
    addr  <= a;
    wdata <= {24'h0, v};
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk);
      if (wait_req === 1'b0)
        break;
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k == 50)
    begin
      fail_count++;
      stop_test();
    end
  endtask : acc

  task rdchk(input logic [3:0] a, input logic [7:0] exp);
    acc(1'b1, a, 8'h00);
    chk(q, {24'h0, exp});
  endtask : rdchk

  // burst of pulses from the pin source, then time for the input filter
  task burst(input logic [3:0] c);
    int k;
    cnt   <= c;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (2) @(posedge clk);
    for (k = 0; k < 400 && busy !== 1'b0; k++)
      @(posedge clk);
    if (k == 400)
    begin
      fail_count++;
      stop_test();
    end
    repeat (8) @(posedge clk);
  endtask : burst

  // count gained between two count reads captured 84 cycles apart
  task span;
    acc(1'b1, CNT, 8'h00);
    d = q[7:0];
    repeat (80) @(posedge clk);
    acc(1'b1, CNT, 8'h00);
    d = q[7:0] - d;
  endtask : span
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {rst_b, rd, wr, addr, wdata, start, cnt} = '0;
    {idle, half, fail_count, comparisons} = {1'b1, 4'h3, 64'h0};
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rdchk(CTL, 8'h00);
    rdchk(MSK, 8'h00);
    rdchk(FLG, 8'h00);
    chk({cap4, cmp5}, 32'h1);
    rdchk(4'hF, 8'h00);
    acc(1'b0, CTL, 8'hFF);
    rdchk(CTL, 8'hFF);
    chk({cap4, cmp5, dir7, dir3, rate}, 32'h2F);
    acc(1'b0, MSK, 8'hFF);
    rdchk(MSK, 8'hF3);
    acc(1'b0, MSK, 8'h00);
    $display("test registers done");
    acc(1'b0, CTL, 8'h40);
    acc(1'b0, CNT, 8'hFE);
    rdchk(CNT, 8'hFE);
    burst(4'h2);
    rdchk(CNT, 8'h00);
    rdchk(FLG, 8'h30);
    chk({ovf_irq, edge_irq}, 32'h0);
    acc(1'b0, MSK, 8'h30);
    @(posedge clk);
    chk({ovf_irq, edge_irq}, 32'h3);
    rdchk(FLG, 8'h30);
    acc(1'b0, FLG, 8'h20);
    rdchk(FLG, 8'h10);
    chk({ovf_irq, edge_irq}, 32'h1);
    acc(1'b0, FLG, 8'h10);
    rdchk(FLG, 8'h00);
    chk(edge_irq, 32'h0);
    $display("test falling events done");
    acc(1'b0, CTL, 8'h00);
    burst(4'h3);
    rdchk(CNT, 8'h00);
    rdchk(FLG, 8'h00);
    idle <= 1'b0;
    repeat (8) @(posedge clk);
    acc(1'b0, CTL, 8'h50);
    half <= 4'h2;
    burst(4'h3);
    rdchk(CNT, 8'h03);
    rdchk(FLG, 8'h10);
    $display("test disabled and rising events done");
    acc(1'b0, CTL, 8'h60);
    span();
    chk(d, 32'h0);
    idle <= 1'b1;
    span();
    chk(d inside {[8'd9:8'd12]}, 32'h1);
    acc(1'b0, CTL, 8'h70);
    span();
    chk(d, 32'h0);
    $display("test gated time done");
    acc(1'b0, CTL, 8'h00);
    acc(1'b0, CNT, 8'h5A);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rdchk(CNT, 8'h5A);
    rdchk(FLG, 8'h00);
    $display("test count across reset done");
    stop_test();
  end
endmodule : pulse_accumulator_tb
